// ---- hw/ilc_ctrl.sv ----
// The AHB-Lite slave port and the register addresses were left to the implementer.
`default_nettype none
// What this block does
// - two mode bits: both zero gives mode 0, low bit one gives mode 1
// - a source reaches priority logic only while its enable bit is one
// - level 1 candidates are chosen before level 0; others stay pending
// - equal level ties resolve by fixed source order
// - mode 0: maskable requests accepted only while primary mask is zero
// - under masking, non-maskable and address break still get accepted
// - mode 1: level 0 enabled only when primary mask is zero
// - mode 1: level 1 enabled unless both mask bits are one
// - mode 1: secondary mask ignored while primary mask is zero
// - mode 1, both masks set: only non-maskable and address break pass
// - exception work starts only after the current instruction ends
// - push resume address and condition code onto the stack
// - mode 0: set primary mask after the stack save
// - mode 1: set both masks after the stack save
// - form vector address, read vector, start handler at its contents
// - priority takes three states for external, two for internal sources
// - instruction end wait lasts one state up to nineteen plus two accesses
// - one internal state after acceptance and one after the vector fetch
// - access costs 1 internal, 4 two-state external, 6+2m three-state
module ilc_ctrl #(
  parameter logic [7:0] VEC_NMI  = 8'h07,
  parameter logic [7:0] VEC_ABRK = 8'h08,
  parameter logic [7:0] VEC_BASE = 8'h10
) (
  input  wire logic                                 clk,
  input  wire logic                                 nrst,
  input  wire logic                                 hsel,
  input  wire logic [7:0]                           haddr,
  input  wire logic [1:0]                           htrans,
  input  wire logic                                 hwrite,
  input  wire logic [2:0]                           hsize,
  input  wire logic [31:0]                          hwdata,
  input  wire logic                                 hready,
  output logic                                      hreadyout,
  output logic                                      hresp,
  output logic [31:0]                               hrdata,
  input  wire logic                                 nmiPin,
  input  wire logic [ilc_pkg::EXT_N-1:0]            extPin,
  input  wire logic                                 abrkReq,
  input  wire logic [ilc_pkg::SRC_N-ilc_pkg::EXT_N-1:0] perReq,
  input  wire logic                                 insnDone,
  input  wire logic [ilc_pkg::PC_W-1:0]             resumePc,
  input  wire logic [ilc_pkg::CCR_W-1:0]            ccrIn,
  input  wire ilc_pkg::ilc_space_t                  memSpace,
  input  wire logic [ilc_pkg::PC_W-1:0]             vecData,
  output logic                                      iMask,
  output logic                                      uiMask,
  output ilc_pkg::ilc_seq_t                         seq
);
  ////////////////////////////////////////////////////////////////////////////
  // registers and internal nets
  logic [7:0]                 ctrl_q;
  logic [ilc_pkg::LEVEL_W-1:0] lvlA_q, lvlB_q, lvlC_q;
  logic [ilc_pkg::SRC_N-1:0]  enable_q;
  logic                       i_q, ui_q;
  logic                       wr_q;
  logic [7:0]                 addr_q;
  ilc_pkg::ilc_state_t        st_q, st_d;
  logic [ilc_pkg::CNT_W-1:0]  cnt_q, cnt_d;
  logic [7:0]                 vecNum_q;
  logic [ilc_pkg::IDX_W-1:0]  idx_q;
  logic [ilc_pkg::PC_W-1:0]   pc_q, handler_q;
  logic [ilc_pkg::CCR_W-1:0]  ccr_q;
  logic [ilc_pkg::EXT_N:0]    pinSync;
  logic [ilc_pkg::SRC_N-1:0]  reqAll, levelVec, cand, cand1, cand0;
  logic                       mode1, any1, any0, selValid, selExt, selMaskable, selLvl1;
  logic [ilc_pkg::IDX_W-1:0]  idx1, idx0, selIdx;
  logic [7:0]                 selNum;
  logic [ilc_pkg::CNT_W-1:0]  accCost, twoAcc;
  logic                       addrPhase, doWrite, hwSetMask;
  logic [31:0]                rdMux;
  ////////////////////////////////////////////////////////////////////////////
  // pins cross into clk through two flops before anyone looks
  ilc_sync #(.W(ilc_pkg::EXT_N + 1)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  ({nmiPin, extPin}),
    .dout (pinSync)
  );
  // levels live, never latched, so a mask or level write re-ranks at once
  assign reqAll   = {perReq, pinSync[ilc_pkg::EXT_N-1:0]};
  assign levelVec = {lvlC_q, lvlB_q, lvlA_q};
  assign mode1    = ctrl_q[ilc_pkg::MODE_LO_BIT];
  // candidates: enabled, then gated by the mask bits of the current mode
  always_comb
  begin
    for (int i = 0; i < ilc_pkg::SRC_N; i++)
    begin
      cand[i] = reqAll[i] & enable_q[i]
              & (~i_q
                 | (mode1 & levelVec[i] & ~ui_q));
    end
  end
  assign cand1 = cand & levelVec;
  assign cand0 = cand & ~levelVec;
  ilc_prio #(.N(ilc_pkg::SRC_N), .IW(ilc_pkg::IDX_W)) u_prio1 (
    .req   (cand1),
    .found (any1),
    .idx   (idx1)
  );
  ilc_prio #(.N(ilc_pkg::SRC_N), .IW(ilc_pkg::IDX_W)) u_prio0 (
    .req   (cand0),
    .found (any0),
    .idx   (idx0)
  );
  // winner: nmi, level 1, address break, level 0; masks never gate nmi or break
  always_comb
  begin
    selValid    = 1'b1;
    selExt      = 1'b0;
    selMaskable = 1'b0;
    selLvl1     = 1'b0;
    selIdx      = '0;
    selNum      = VEC_NMI;
    if (pinSync[ilc_pkg::EXT_N])
    begin
      selExt = 1'b1;
    end
    else if (any1)
    begin
      selMaskable = 1'b1;
      selLvl1     = 1'b1;
      selIdx      = idx1;
      selExt      = idx1 < ilc_pkg::IDX_W'(ilc_pkg::EXT_N);
      selNum      = VEC_BASE + 8'(idx1);
    end
    else if (abrkReq)
    begin
      selNum = VEC_ABRK;
    end
    else if (any0)
    begin
      selMaskable = 1'b1;
      selIdx      = idx0;
      selExt      = idx0 < ilc_pkg::IDX_W'(ilc_pkg::EXT_N);
      selNum      = VEC_BASE + 8'(idx0);
    end
    else
    begin
      selValid = 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // cost of one access for the space the sequencer reports
  always_comb
  begin
    case (memSpace)
      ilc_pkg::SP_INT:  accCost = ilc_pkg::ACC_INT_ST;
      ilc_pkg::SP_EXT2: accCost = ilc_pkg::ACC_EXT2_ST;
      ilc_pkg::SP_EXT3: accCost = ilc_pkg::ACC_EXT3_BASE
                          + {2'h0, ctrl_q[ilc_pkg::WAIT_LSB +: ilc_pkg::WAIT_W], 1'b0};
      default:          accCost = ilc_pkg::ACC_INT_ST;
    endcase
  end
  assign twoAcc = accCost << 1; // two accesses per stack, vector, fetch step
  // sequencer next state
  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_q - 7'h01;
    case (st_q)
      ilc_pkg::ST_IDLE:
      begin
        cnt_d = '0;
        if (selValid)
        begin
          st_d  = ilc_pkg::ST_PRIO;
          cnt_d = (selExt ? ilc_pkg::PRIO_EXT_ST : ilc_pkg::PRIO_INT_ST) - 7'h01;
        end
      end
      ilc_pkg::ST_PRIO:
      begin
        if (!selValid)
        begin
          st_d = ilc_pkg::ST_IDLE; // source withdrew before acceptance
        end
        else if (cnt_q == '0)
        begin
          st_d = ilc_pkg::ST_WAITI;
        end
      end
      ilc_pkg::ST_WAITI:
      begin
        cnt_d = '0;
        if (insnDone)
        begin
          st_d = ilc_pkg::ST_INTA;
        end
      end
      ilc_pkg::ST_INTA:
      begin
        st_d  = ilc_pkg::ST_STACK;
        cnt_d = twoAcc - 7'h01;
      end
      ilc_pkg::ST_STACK:
      begin
        if (cnt_q == '0)
        begin
          st_d  = ilc_pkg::ST_VECF;
          cnt_d = twoAcc - 7'h01;
        end
      end
      ilc_pkg::ST_VECF:
      begin
        if (cnt_q == '0)
        begin
          st_d = ilc_pkg::ST_INTB;
        end
      end
      ilc_pkg::ST_INTB:
      begin
        st_d  = ilc_pkg::ST_FETCH;
        cnt_d = twoAcc - 7'h01;
      end
      ilc_pkg::ST_FETCH:
      begin
        if (cnt_q == '0)
        begin
          st_d = ilc_pkg::ST_IDLE;
        end
      end
      default:
      begin
        st_d  = ilc_pkg::ST_IDLE;
        cnt_d = '0;
      end
    endcase
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q  <= ilc_pkg::ST_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end
  // winner frozen at the end of ranking; losers simply stay pending
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      vecNum_q  <= '0;
      idx_q     <= '0;
      pc_q      <= '0;
      ccr_q     <= '0;
      handler_q <= '0;
    end
    else
    begin
      if (st_q == ilc_pkg::ST_PRIO && st_d == ilc_pkg::ST_WAITI)
      begin
        vecNum_q <= selNum;
        idx_q    <= selIdx;
      end
      if (st_q == ilc_pkg::ST_WAITI && insnDone)
      begin
        pc_q  <= resumePc;
        ccr_q <= ccrIn;
      end
      if (st_q == ilc_pkg::ST_VECF && cnt_q == '0)
      begin
        handler_q <= vecData;
      end
    end
  end
  // sequencer outputs, all registered pulses or levels
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      seq <= '0;
    end
    else
    begin
      seq.busy      <= st_d != ilc_pkg::ST_IDLE;
      seq.ackValid  <= st_q == ilc_pkg::ST_PRIO && st_d == ilc_pkg::ST_WAITI && selMaskable;
      seq.ackIdx    <= selIdx;
      seq.push      <= st_q == ilc_pkg::ST_INTA;
      seq.pushData  <= {ccr_q, pc_q};
      seq.vecFetch  <= st_q == ilc_pkg::ST_STACK && cnt_q == '0;
      seq.vecAddr   <= {14'h0000, vecNum_q, 2'h0};
      seq.handlerGo <= st_q == ilc_pkg::ST_FETCH && cnt_q == '0;
      seq.handlerAddr <= handler_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait, always okay
  assign addrPhase = hsel & htrans[1] & hready;
  assign doWrite   = wr_q;
  assign hwSetMask = st_q == ilc_pkg::ST_STACK && cnt_q == '0;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign iMask     = i_q;
  assign uiMask    = ui_q;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_q   <= 1'b0;
      addr_q <= '0;
    end
    else
    begin
      wr_q   <= addrPhase & hwrite & (hsize == 3'h2);
      addr_q <= haddr;
    end
  end
  // config registers steered by software
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q   <= ilc_pkg::CTRL_RST;
      lvlA_q   <= ilc_pkg::LEVEL_RST;
      lvlB_q   <= ilc_pkg::LEVEL_RST;
      lvlC_q   <= ilc_pkg::LEVEL_RST;
      enable_q <= ilc_pkg::ENABLE_RST;
    end
    else if (doWrite)
    begin
      case (addr_q)
        ilc_pkg::OFS_CTRL:    ctrl_q   <= hwdata[7:0];
        ilc_pkg::OFS_LEVEL_A: lvlA_q   <= hwdata[7:0];
        ilc_pkg::OFS_LEVEL_B: lvlB_q   <= hwdata[7:0];
        ilc_pkg::OFS_LEVEL_C: lvlC_q   <= hwdata[7:0];
        ilc_pkg::OFS_ENABLE:  enable_q <= hwdata[ilc_pkg::SRC_N-1:0];
        default:              ctrl_q   <= ctrl_q;
      endcase
    end
  end
  // mask bits: hardware set after the stack save beats a same-cycle write
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      i_q  <= ilc_pkg::MASK_RST[ilc_pkg::MASK_I_BIT];
      ui_q <= ilc_pkg::MASK_RST[ilc_pkg::MASK_UI_BIT];
    end
    else if (hwSetMask)
    begin
      i_q  <= 1'b1;
      ui_q <= mode1 | (doWrite && addr_q == ilc_pkg::OFS_MASK ? hwdata[ilc_pkg::MASK_UI_BIT] : ui_q);
    end
    else if (doWrite && addr_q == ilc_pkg::OFS_MASK)
    begin
      i_q  <= hwdata[ilc_pkg::MASK_I_BIT];
      ui_q <= hwdata[ilc_pkg::MASK_UI_BIT];
    end
  end
  // read data sampled in the address phase; unmapped reads return zero
  always_comb
  begin
    case (haddr)
      ilc_pkg::OFS_CTRL:    rdMux = {24'h000000, ctrl_q};
      ilc_pkg::OFS_LEVEL_A: rdMux = {24'h000000, lvlA_q};
      ilc_pkg::OFS_LEVEL_B: rdMux = {24'h000000, lvlB_q};
      ilc_pkg::OFS_LEVEL_C: rdMux = {24'h000000, lvlC_q};
      ilc_pkg::OFS_ENABLE:  rdMux = {8'h00, enable_q};
      ilc_pkg::OFS_MASK:    rdMux = {30'h00000000, ui_q, i_q};
      ilc_pkg::OFS_STATUS:  rdMux = {16'h0000, vecNum_q, 3'h0, selValid, 1'b0, st_q};
      ilc_pkg::OFS_PENDING: rdMux = {8'h00, reqAll & enable_q};
      default:              rdMux = 32'h00000000;
    endcase
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hrdata <= '0;
    end
    else if (addrPhase && !hwrite)
    begin
      hrdata <= rdMux;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic startPrio;
  assign startPrio = st_q == ilc_pkg::ST_IDLE && selValid;
  // matched at the last ranking state: looks back to the idle state, then one step on
  sequence s_prio3;
    st_q == ilc_pkg::ST_PRIO && $past(st_q, 1) == ilc_pkg::ST_PRIO && $past(st_q, 2) == ilc_pkg::ST_PRIO
      && $past(st_q, 3) == ilc_pkg::ST_IDLE ##1 st_q == ilc_pkg::ST_WAITI;
  endsequence
  sequence s_prio2;
    st_q == ilc_pkg::ST_PRIO && $past(st_q, 1) == ilc_pkg::ST_PRIO
      && $past(st_q, 2) == ilc_pkg::ST_IDLE ##1 st_q == ilc_pkg::ST_WAITI;
  endsequence
  property p_prio_ext;
    @(posedge clk) disable iff (!nrst)
    startPrio && selExt ##1 selValid [*3] |-> s_prio3;
  endproperty
  a_prio_ext: assert property (p_prio_ext) else $error("external ranking not three states");
  property p_prio_int;
    @(posedge clk) disable iff (!nrst)
    startPrio && !selExt ##1 selValid [*2] |-> s_prio2;
  endproperty
  a_prio_int: assert property (p_prio_int) else $error("internal ranking not two states");
  property p_enable;
    @(posedge clk) disable iff (!nrst)
    (cand & ~enable_q) == '0;
  endproperty
  a_enable: assert property (p_enable) else $error("disabled source reached ranking");
  property p_mode0_mask;
    @(posedge clk) disable iff (!nrst)
    startPrio && !mode1 && i_q |-> !selMaskable;
  endproperty
  a_mode0_mask: assert property (p_mode0_mask) else $error("maskable taken under mask");
  property p_mode1_both;
    @(posedge clk) disable iff (!nrst)
    startPrio && mode1 && i_q && ui_q |-> !selMaskable;
  endproperty
  a_mode1_both: assert property (p_mode1_both) else $error("maskable taken with both masks");
  property p_mode1_lvl;
    @(posedge clk) disable iff (!nrst)
    startPrio && mode1 && i_q && selMaskable |-> selLvl1 && !ui_q;
  endproperty
  a_mode1_lvl: assert property (p_mode1_lvl) else $error("level 0 taken with primary mask");
  property p_lvl_first;
    @(posedge clk) disable iff (!nrst)
    any1 && !pinSync[ilc_pkg::EXT_N] |-> selLvl1;
  endproperty
  a_lvl_first: assert property (p_lvl_first) else $error("level 1 not preferred");
  property p_insn_end;
    @(posedge clk) disable iff (!nrst)
    st_q == ilc_pkg::ST_WAITI && !insnDone |=> st_q == ilc_pkg::ST_WAITI;
  endproperty
  a_insn_end: assert property (p_insn_end) else $error("left wait before instruction end");
  property p_set_mask;
    @(posedge clk) disable iff (!nrst)
    st_q == ilc_pkg::ST_STACK ##1 st_q == ilc_pkg::ST_VECF |-> i_q && (ui_q || !mode1);
  endproperty
  a_set_mask: assert property (p_set_mask) else $error("masks not set after stack save");
  property p_internal;
    @(posedge clk) disable iff (!nrst)
    st_q == ilc_pkg::ST_INTA |=> st_q == ilc_pkg::ST_STACK && seq.push
      && seq.pushData[ilc_pkg::PC_W-1:0] == pc_q;
  endproperty
  a_internal: assert property (p_internal) else $error("acceptance step or push wrong");
  property p_vec;
    @(posedge clk) disable iff (!nrst)
    seq.vecFetch |-> seq.vecAddr == {14'h0000, vecNum_q, 2'h0} && st_q == ilc_pkg::ST_VECF;
  endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");
  property p_stack_cost;
    @(posedge clk) disable iff (!nrst)
    st_q == ilc_pkg::ST_INTA |=> cnt_q == $past(twoAcc) - 7'h01;
  endproperty
  a_stack_cost: assert property (p_stack_cost) else $error("stack save length wrong");
endmodule : ilc_ctrl
`default_nettype wire

// ---- hw/ilc_prio.sv ----
`default_nettype none
module ilc_prio #(
  parameter int N = 8,
  parameter int IW = 3
) (
  input  wire logic [N-1:0]  req,
  output logic               found,
  output logic [IW-1:0]      idx
);
  // lowest index wins: fixed default order, index 0 first
  always_comb
  begin
    found = 1'b0;
    idx   = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        found = 1'b1;
        idx   = IW'(i);
      end
    end
  end
endmodule : ilc_prio
`default_nettype wire

// ---- hw/ilc_sync.sv ----
`default_nettype none
module ilc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  // two flops per pin; only the second stage is read
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= '0;
      dout   <= '0;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : ilc_sync
`default_nettype wire

// ---- pkg/ilc_pkg.sv ----
`default_nettype none
package ilc_pkg;
  // source population
  localparam int SRC_N = 24;
  localparam int EXT_N = 4;
  localparam int IDX_W = 5;
  localparam int PC_W  = 24;
  localparam int CCR_W = 8;
  localparam int CNT_W = 7;
  localparam int VEC_W = 8;
  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_LEVEL_A = 8'h04;
  localparam logic [7:0] OFS_LEVEL_B = 8'h08;
  localparam logic [7:0] OFS_LEVEL_C = 8'h0C;
  localparam logic [7:0] OFS_ENABLE  = 8'h10;
  localparam logic [7:0] OFS_MASK    = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam logic [7:0] OFS_PENDING = 8'h1C;
  // field positions
  localparam int MODE_LO_BIT = 0;
  localparam int MODE_HI_BIT = 1;
  localparam int WAIT_LSB    = 4;
  localparam int WAIT_W      = 4;
  localparam int MASK_I_BIT  = 0;
  localparam int MASK_UI_BIT = 1;
  localparam int LEVEL_W     = 8;
  // reset values
  localparam logic [7:0]       CTRL_RST   = 8'h00;
  localparam logic [1:0]       MASK_RST   = 2'h1;
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 8'h00;
  localparam logic [SRC_N-1:0] ENABLE_RST = 24'h000000;
  ////////////////////////////////////////////////////////////////////////////
  // timing in states (one state is one clk cycle)
  localparam logic [CNT_W-1:0] PRIO_EXT_ST   = 7'h03;
  localparam logic [CNT_W-1:0] PRIO_INT_ST   = 7'h02;
  localparam logic [CNT_W-1:0] ACC_INT_ST    = 7'h01;
  localparam logic [CNT_W-1:0] ACC_EXT2_ST   = 7'h04;
  localparam logic [CNT_W-1:0] ACC_EXT3_BASE = 7'h06;
  typedef enum logic [1:0] {SP_INT = 2'h0, SP_EXT2 = 2'h1, SP_EXT3 = 2'h2} ilc_space_t;
  // gray along idle..fetch
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_PRIO = 3'h1, ST_WAITI = 3'h3, ST_INTA = 3'h2,
    ST_STACK = 3'h6, ST_VECF = 3'h7, ST_INTB = 3'h5, ST_FETCH = 3'h4
  } ilc_state_t;
  typedef struct packed {
    logic                   busy;
    logic                   ackValid;
    logic [IDX_W-1:0]       ackIdx;
    logic                   push;
    logic [CCR_W+PC_W-1:0]  pushData;
    logic                   vecFetch;
    logic [PC_W-1:0]        vecAddr;
    logic                   handlerGo;
    logic [PC_W-1:0]        handlerAddr;
  } ilc_seq_t;
endpackage : ilc_pkg
`default_nettype wire

// ---- tb/ilc_cpu_model.sv ----
`default_nettype none
module ilc_cpu_model #(
  parameter logic [23:0] KEY = 24'h5A5A5A
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire ilc_pkg::ilc_seq_t seq,
  input  wire logic [4:0]        lag,
  output logic                   insnDone,
  output logic [23:0]            resumePc,
  output logic [7:0]             ccrIn,
  output logic [23:0]            vecData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0]  waitCnt;
  logic [23:0] vecHeld;
  //////////////////////////////////////////////////////////////////////////////
  // instruction end comes lag cycles into a sequence; lag 19 stands for a long multiply or divide
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      waitCnt  <= 5'h00;
      insnDone <= 1'b0;
    end
    else
    begin
      waitCnt  <= (seq.busy && !seq.ackValid) ? waitCnt + 5'h01 : 5'h00;
      insnDone <= seq.busy && !seq.ackValid && (waitCnt >= lag);
    end
  // pc and ccr hold only while busy; outside they churn so a late capture shows up
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      resumePc <= 24'h000100;
      ccrIn    <= 8'h00;
    end
    else if (!seq.busy)
    begin
      resumePc <= resumePc + 24'h000102;
      ccrIn    <= ccrIn + 8'h35;
    end
  // vector word is answered with the fetch and held until the handler starts
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      vecHeld <= 24'h000000;
    else if (seq.vecFetch)
      vecHeld <= seq.vecAddr ^ KEY;
    else if (!seq.busy)
      vecHeld <= ~vecHeld;
  assign vecData = seq.vecFetch ? (seq.vecAddr ^ KEY) : vecHeld;
endmodule : ilc_cpu_model
`default_nettype wire

// ---- tb/tb.sv ----
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] KEY = 24'h5A5A5A;
  localparam logic [7:0]  VN  = 8'h07;
  localparam logic [7:0]  VA  = 8'h08;
  localparam logic [7:0]  VB  = 8'h10;
  logic               clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0]         haddr = 8'h00;
  logic [1:0]         htrans = 2'h0;
  logic [2:0]         hsize = 3'h2;
  logic [31:0]        hwdata = 32'h0, hrdata, rs = 32'h2838;
  logic               hreadyout, iMask, uiMask, insnDone, nmiPin = 1'b0, abrkReq = 1'b0;
  logic [19:0]        perReq = 20'h0;
  logic [3:0]         extPin = 4'h0;
  logic [4:0]         lag = 5'h00;
  logic [23:0]        resumePc, vecData;
  logic [7:0]         ccrIn;
  ilc_pkg::ilc_space_t memSpace = ilc_pkg::SP_INT;
  ilc_pkg::ilc_seq_t  seq;
  int                 error_cnt = 0, checked = 0, cyc = 0;
  always #4 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  ilc_ctrl #(.VEC_NMI(VN), .VEC_ABRK(VA), .VEC_BASE(VB)) i_ilc_ctrl (.clk(clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .nmiPin(nmiPin), .extPin(extPin), .abrkReq(abrkReq),
    .perReq(perReq), .insnDone(insnDone), .resumePc(resumePc), .ccrIn(ccrIn), .memSpace(memSpace),
    .vecData(vecData), .iMask(iMask), .uiMask(uiMask), .seq(seq));
  ilc_cpu_model #(.KEY(KEY)) i_ilc_cpu_model (.clk(clk), .nrst(nrst), .seq(seq), .lag(lag),
    .insnDone(insnDone), .resumePc(resumePc), .ccrIn(ccrIn), .vecData(vecData));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  // reference picker: level 1, address break 32, then level 0; lowest index wins a tie
  function automatic int pick(int m1, int im, int ui, logic [23:0] lv, logic [23:0] rq, int ab);
    int best;
    best = -1;
    for (int i = 23; i >= 0; i--)
      if (rq[i] && lv[i] && (im == 0 || (m1 != 0 && ui == 0)))
        best = i;
    if (best < 0 && ab != 0)
      best = 32;
    if (best < 0 && im == 0)
      for (int i = 23; i >= 0; i--)
        if (rq[i])
          best = i;
    return best;
  endfunction : pick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rdc
  // follow one sequence to the handler start and judge what it pushed and fetched
  task automatic waitrun(input int exp, input int m1);
    logic [31:0] va, pd, ep, ai, ev;
    logic        seen;
    seen = 1'b0;
    ai = 32'hFFFFFFFF;
    pd = 32'h0;
    ep = 32'h1;
    va = 32'h0;
    ev = {22'h0, (exp == 33) ? VN : (exp == 32) ? VA : VB + 8'(exp), 2'h0};
    for (int k = 0; k < 400 && seq.handlerGo !== 1'b1; k++)
    begin
      @(posedge clk);
      if (seq.ackValid === 1'b1)
        ai = 32'(seq.ackIdx);
      if (seq.push === 1'b1)
        {pd, ep} = {seq.pushData, ccrIn, resumePc};
      if (seq.vecFetch === 1'b1)
        {seen, va} = {1'b1, 8'h0, seq.vecAddr};
    end
    if (exp < 0)
      chk(32'(seen), 32'h0);
    else
    begin
      perReq  <= 20'h0;
      extPin  <= 4'h0;
      abrkReq <= 1'b0;
      nmiPin  <= 1'b0;
      chk(va, ev);
      chk(32'(seq.handlerAddr), ev ^ 32'(KEY));
      chk(pd, ep);
      chk(ai, (exp < 24) ? 32'(exp) : 32'hFFFFFFFF);
      chk({30'h0, iMask, uiMask | (m1 == 0)}, 32'h3);
      for (int k = 0; k < 400 && seq.busy !== 1'b0; k++) @(posedge clk);
    end
  endtask : waitrun
  // random mode, levels, enables, masks and peripheral requests against the reference picker
  task automatic trial();
    logic [31:0] r;
    logic [23:0] en, lv, rq;
    int          exp;
    r = rnd();
    en = 24'(rnd());
    lv = 24'(rnd());
    rq = 24'(rnd());
    lag <= 5'(rnd() % 20);
    memSpace <= ilc_pkg::ilc_space_t'(2'(rnd() % 3));
    wr(ilc_pkg::OFS_CTRL, {24'h0, r[11:8], 3'h0, r[0]});
    wr(ilc_pkg::OFS_LEVEL_A, {24'h0, lv[7:0]});
    wr(ilc_pkg::OFS_LEVEL_B, {24'h0, lv[15:8]});
    wr(ilc_pkg::OFS_LEVEL_C, {24'h0, lv[23:16]});
    wr(ilc_pkg::OFS_ENABLE, {8'h0, en});
    wr(ilc_pkg::OFS_MASK, {30'h0, r[2:1]});
    perReq  <= rq[23:4];
    extPin  <= rq[3:0];
    abrkReq <= (r[4:3] == 2'h0);
    exp = pick(r[0], r[1], r[2], lv, rq & en, r[4:3] == 2'h0);
    waitrun(exp, r[0]);
    if (exp < 0)
    begin
      wr(ilc_pkg::OFS_MASK, 32'h0);
      exp = pick(r[0], 0, 0, lv, rq & en, r[4:3] == 2'h0);
      waitrun(exp, r[0]);
    end
    perReq  <= 20'h0;
    extPin  <= 4'h0;
    abrkReq <= 1'b0;
    @(posedge clk);
  endtask : trial
  task automatic conclude();
    $display("errors %0d of %0d checks", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  //////////////////////////////////////////////////////////////////////////////
  // cycle ceiling: about three and a half times the worst case of all trials
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      error_cnt++;
      conclude();
    end
  end
  // main sequence: reset values, unmapped place, random trials, nmi under full masking
  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rdc(ilc_pkg::OFS_MASK, 32'(ilc_pkg::MASK_RST));
    rdc(ilc_pkg::OFS_CTRL, 32'(ilc_pkg::CTRL_RST));
    rdc(ilc_pkg::OFS_ENABLE, 32'(ilc_pkg::ENABLE_RST));
    wr(8'h20, 32'hFFFFFFFF);
    rdc(8'h20, 32'h0);
    repeat (30) trial();
    wr(ilc_pkg::OFS_CTRL, 32'h1);
    wr(ilc_pkg::OFS_MASK, 32'h3);
    nmiPin <= 1'b1;
    waitrun(33, 1);
    conclude();
  end
endmodule : tb
`default_nettype wire
